// ===== hdl/appd_pkg.sv
// Shared constants for the converter pair power-state control link.
// Assumes a single 25 MHz clock shared by the device end and host end.
package appd_pkg;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned PAIR_COUNT = 3;
	// Conversion time of one pair, in ns, and its cycle count.
	localparam int unsigned CONV_TIME_NS = 3000;
	localparam int unsigned CONV_CYCLES =
		(CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Recovery from partial power-down, least time in ns.
	localparam int unsigned PPD_RECOVER_NS = 1000;
	localparam int unsigned PPD_RECOVER_CYCLES =
		(PPD_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Wake-up from standby, least time in ns.
	localparam int unsigned WAKE_NS = 2000;
	localparam int unsigned WAKE_CYCLES =
		(WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 16;
	localparam logic [2:0] PAIRS_NONE = 3'h0;
	// Result word per pair, width of the widest channel.
	localparam int unsigned RESULT_W = 16;
endpackage : appd_pkg

// ===== hdl/appd_link_if.sv
// Pins between the host sequencer and the converter power control.
// Assumes both ends run on the same clock; the bench joins them.
`timescale 1ns/1ps
interface appd_link_if;
	logic [2:0] pair_sample_trigger;
	logic low_power_hold_n;
	logic busy;

	// Device end samples the host pins and drives busy.
	modport dev (
		input pair_sample_trigger,
		input low_power_hold_n,
		output busy
	);

	// Host end drives the pins and watches busy.
	modport host (
		output pair_sample_trigger,
		output low_power_hold_n,
		input busy
	);
endinterface : appd_link_if

// ===== hdl/appd_device.sv
// Device end: per-pair conversion, partial power-down and standby.
// Assumes host pins come from outside the clock domain and are
// synchronised here through three flip-flops.
//
// Behaviour
// RULE1: Trigger low before busy falls: pair powers down.
// RULE2: Only pairs converting this cycle may power down.
// RULE3: Raising trigger wakes pair into track mode.
// RULE4: Host waits recovery time before next rising edge.
// RULE5: Reference buffers stay powered during partial power-down.
// RULE6: Powered pairs keep converting while others sleep.
// RULE7: Low standby input enters standby; high leaves.
// RULE8: Result buffers stay readable during standby.
// RULE9: Host may enter standby at busy fall.
// RULE10: Host waits wake-up interval after leaving standby.
// RULE11: Rising trigger starts conversion; busy falls when done.
// RULE12: Recovery and wake-up times are parameters.
`timescale 1ns/1ps
module appd_device #(
	parameter int unsigned PPD_CYCLES = appd_pkg::PPD_RECOVER_CYCLES,
	parameter int unsigned WAKEUP_CYCLES = appd_pkg::WAKE_CYCLES
) (
	input wire logic clock,
	input wire logic rst_b,
	appd_link_if.dev link,
	input wire logic [2:0] sample_in_valid,
	output logic [2:0] pair_powered_down,
	output logic [2:0] pair_ready,
	output logic standby_active,
	output logic device_ready,
	output logic reference_on,
	output logic [2:0] result_fresh,
	output logic [47:0] result_data
);
	typedef enum logic [2:0] {
		APPD_IDLE = 3'b001,
		APPD_CONV = 3'b010,
		APPD_DONE = 3'b100
	} appd_state_e;

	appd_state_e state_q;
	appd_state_e state_d;
	logic [2:0] trig_s1_q, trig_s2_q, trig_s3_q, trig_q;
	logic [2:0] hold_s_q;
	logic hold_q;
	logic [appd_pkg::CNT_W-1:0] conv_cnt_q;
	logic [2:0] active_q;
	logic [2:0] ppd_q;
	logic [appd_pkg::CNT_W-1:0] rec_cnt_q [3];
	logic [appd_pkg::CNT_W-1:0] wake_cnt_q;
	logic [appd_pkg::RESULT_W-1:0] result_q [3];
	logic [2:0] fresh_q;
	logic [appd_pkg::RESULT_W-1:0] sample_ctr_q;

	// Down-counter helpers shared by the conversion, recovery and wake
	// timers; for recovery and wake a zero count means the wait is over.
	function automatic logic appd_zero(
		input logic [appd_pkg::CNT_W-1:0] v
	);
		return v == '0;
	endfunction : appd_zero

	// Recovery and wake callers test for zero first, and the conversion timer leaves at one, so the step never wraps.
	function automatic logic [appd_pkg::CNT_W-1:0] appd_dec(
		input logic [appd_pkg::CNT_W-1:0] v
	);
		return v - appd_pkg::CNT_W'(1);
	endfunction : appd_dec

	// Three-stage synchronisers; a change counts once stages 2 and 3
	// agree, so the first stage is never read by logic.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			trig_s1_q <= 3'h0;
			trig_s2_q <= 3'h0;
			trig_s3_q <= 3'h0;
			hold_s_q <= 3'h7;
		end else begin
			trig_s1_q <= link.pair_sample_trigger;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
			hold_s_q <= {hold_s_q[1:0], link.low_power_hold_n};
		end
	end

	// Filtered levels update only where stages 2 and 3 agree.
	wire [2:0] trig_agree = ~(trig_s2_q ^ trig_s3_q);
	wire [2:0] trig_d = (trig_agree & trig_s3_q) | (~trig_agree & trig_q);
	wire hold_agree = hold_s_q[1] == hold_s_q[2];
	wire hold_d = hold_agree ? hold_s_q[2] : hold_q;
	wire [2:0] trig_rise = trig_d & ~trig_q;

	// A pair may start only when powered, recovered and not in standby.
	wire [2:0] rec_done;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_rec
			assign rec_done[g] = appd_zero(rec_cnt_q[g]);
		end
	endgenerate
	wire awake = hold_q && appd_zero(wake_cnt_q);
	wire [2:0] can_start = ~ppd_q & rec_done & {3{awake}};
	wire [2:0] start_mask = trig_rise & can_start; // [RULE11] [RULE6]
	wire conv_last = conv_cnt_q == appd_pkg::CNT_W'(1);
	wire busy_fall = (state_q == APPD_CONV) && conv_last;

	// Busy covers one conversion window started by a rise on any pair able to start.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			APPD_IDLE: begin
				if (start_mask != appd_pkg::PAIRS_NONE)
					state_d = APPD_CONV; // [RULE11]
			end
			APPD_CONV: begin
				if (conv_last)
					state_d = APPD_DONE;
			end
			APPD_DONE: begin
				state_d = APPD_IDLE;
			end
			default: state_d = APPD_IDLE;
		endcase
	end

	// Conversion timer and set of pairs taking part.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= APPD_IDLE;
			conv_cnt_q <= '0;
			active_q <= 3'h0;
			trig_q <= 3'h0;
			hold_q <= 1'b1;
		end else begin
			state_q <= state_d;
			trig_q <= trig_d;
			hold_q <= hold_d; // [RULE7]
			if (state_q == APPD_IDLE && state_d == APPD_CONV) begin
				conv_cnt_q <= appd_pkg::CNT_W'(appd_pkg::CONV_CYCLES);
				active_q <= start_mask;
			end else if (state_q == APPD_CONV) begin
				conv_cnt_q <= appd_dec(conv_cnt_q);
			end
		end
	end

	// Partial power-down: only converting pairs whose trigger is low
	// at busy fall sleep; a trigger rise wakes and starts recovery.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ppd_q <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				rec_cnt_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (busy_fall && active_q[i] && !trig_q[i]) begin
					ppd_q[i] <= 1'b1; // [RULE1] [RULE2]
				end else if (ppd_q[i] && trig_rise[i]) begin
					ppd_q[i] <= 1'b0; // [RULE3]
					rec_cnt_q[i] <= appd_pkg::CNT_W'(PPD_CYCLES); // [RULE4] [RULE12]
				end else if (!appd_zero(rec_cnt_q[i])) begin
					rec_cnt_q[i] <= appd_dec(rec_cnt_q[i]);
				end
			end
		end
	end

	// Standby wake-up timer starts when the hold input goes high.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wake_cnt_q <= '0;
		end else if (!hold_d) begin
			wake_cnt_q <= appd_pkg::CNT_W'(WAKEUP_CYCLES); // [RULE10] [RULE12]
		end else if (!appd_zero(wake_cnt_q)) begin
			wake_cnt_q <= appd_dec(wake_cnt_q);
		end
	end

	// Result store is never gated by standby, so reads keep working.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sample_ctr_q <= '0;
			fresh_q <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				result_q[i] <= '0;
			end
		end else begin
			sample_ctr_q <= sample_ctr_q + appd_pkg::RESULT_W'(1);
			for (int i = 0; i < 3; i++) begin
				if (busy_fall) begin
					// Pairs not converting report zero.
					result_q[i] <= active_q[i] ? sample_ctr_q : '0;
					fresh_q[i] <= active_q[i] & sample_in_valid[i];
				end
			end
		end
	end

	assign link.busy = state_q == APPD_CONV; // [RULE11]
	assign pair_powered_down = ppd_q;
	assign pair_ready = can_start;
	assign standby_active = ~hold_q; // [RULE7]
	assign device_ready = awake;
	// Reference stays up in partial power-down; only standby drops it.
	assign reference_on = hold_q; // [RULE5]
	assign result_fresh = fresh_q;
	assign result_data = {result_q[2], result_q[1], result_q[0]}; // [RULE8]
endmodule : appd_device

// ===== hdl/appd_host.sv
// Host end: drives triggers and standby, honouring recovery timing.
// Assumes the device end shares this clock; busy is synchronised anyway.
`timescale 1ns/1ps
module appd_host #(
	parameter int unsigned PPD_CYCLES = appd_pkg::PPD_RECOVER_CYCLES,
	parameter int unsigned WAKEUP_CYCLES = appd_pkg::WAKE_CYCLES
) (
	input wire logic clock,
	input wire logic rst_b,
	appd_link_if.host link,
	input wire logic [2:0] convert_req,
	input wire logic [2:0] sleep_after,
	input wire logic standby_between,
	output logic req_ready,
	output logic conv_done
);
	logic [2:0] trig_q;
	logic hold_n_q;
	logic [2:0] busy_s_q;
	logic busy_q;
	logic [appd_pkg::CNT_W-1:0] wait_cnt_q;
	logic [2:0] pend_sleep_q;
	logic [2:0] asleep_q;
	logic phase_q;

	// Busy from the pin passes three flops; change once 2 and 3 agree.
	wire busy_agree = busy_s_q[1] == busy_s_q[2];
	wire busy_d = busy_agree ? busy_s_q[2] : busy_q;
	wire busy_fall = busy_q && !busy_d;
	wire idle = !busy_d && !busy_q && wait_cnt_q == '0 && !phase_q;
	wire [2:0] wake_mask = convert_req & asleep_q;
	// A request that names a sleeping pair is held back until its wake
	// is over, so it is never seen as taken while only the wake runs.
	assign req_ready = idle && hold_n_q &&
		wake_mask == appd_pkg::PAIRS_NONE;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			busy_s_q <= 3'h0;
			busy_q <= 1'b0;
		end else begin
			busy_s_q <= {busy_s_q[1:0], link.busy};
			busy_q <= busy_d;
		end
	end

	// Sequencer: wake sleeping pairs and wait, then pulse triggers.
	// Pairs set to sleep hold trigger low through busy fall.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			trig_q <= 3'h0;
			hold_n_q <= 1'b1;
			wait_cnt_q <= '0;
			pend_sleep_q <= 3'h0;
			asleep_q <= 3'h0;
			phase_q <= 1'b0;
			conv_done <= 1'b0;
		end else begin
			conv_done <= busy_fall;
			if (wait_cnt_q != '0)
				wait_cnt_q <= wait_cnt_q - appd_pkg::CNT_W'(1);
			if (busy_fall) begin
				// All triggers drop so the next request gives a clean rise;
				// the device judged power-down at its own busy fall.
				asleep_q <= asleep_q | pend_sleep_q; // [RULE1]
				trig_q <= appd_pkg::PAIRS_NONE;
				pend_sleep_q <= 3'h0;
				if (standby_between)
					hold_n_q <= 1'b0; // [RULE9]
			end else if (idle && !hold_n_q && convert_req != 3'h0) begin
				hold_n_q <= 1'b1; // [RULE9]
				wait_cnt_q <= appd_pkg::CNT_W'(WAKEUP_CYCLES + 8); // [RULE10]
			end else if (idle && wake_mask != 3'h0) begin
				trig_q <= trig_q | wake_mask; // [RULE3]
				asleep_q <= asleep_q & ~wake_mask;
				wait_cnt_q <= appd_pkg::CNT_W'(PPD_CYCLES + 8); // [RULE4]
				phase_q <= 1'b1;
			end else if (phase_q && wait_cnt_q == '0) begin
				// Drop triggers so the next request gives a clean rise.
				trig_q <= 3'h0;
				phase_q <= 1'b0;
				wait_cnt_q <= appd_pkg::CNT_W'(4);
			end else if (req_ready && convert_req != 3'h0) begin
				trig_q <= convert_req; // [RULE11]
				pend_sleep_q <= convert_req & sleep_after;
			end else if (busy_q && pend_sleep_q != 3'h0) begin
				trig_q <= trig_q & ~pend_sleep_q; // [RULE1]
			end
		end
	end

	assign link.pair_sample_trigger = trig_q;
	assign link.low_power_hold_n = hold_n_q;
endmodule : appd_host

// ===== sim/appd_properties.sv
// Timing checks on the pins between the host end and converter end.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/1ps
module appd_properties #(
	parameter int unsigned PPD_CYCLES = 3,
	parameter int unsigned WAKEUP_CYCLES = 3
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [2:0] pair_sample_trigger,
	input wire logic low_power_hold_n,
	input wire logic busy
);
	logic [2:0] trig_q, conv_q, slp_q;
	logic [7:0] since_q, bcnt_q;
	logic [7:0] rec_q [3];
	logic [15:0] wake_q;
	wire [2:0] rise = pair_sample_trigger & ~trig_q;
	wire busy_fall = bcnt_q != 8'h0 && !busy;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	// Ages saturate so that a long idle stretch never wraps into a fail.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			trig_q <= 3'h0;
			conv_q <= 3'h0;
			slp_q <= 3'h0;
			bcnt_q <= 8'h0;
			since_q <= 8'hff;
			wake_q <= 16'(WAKEUP_CYCLES);
			rec_q <= '{8'hff, 8'hff, 8'hff};
		end else begin
			trig_q <= pair_sample_trigger;
			bcnt_q <= busy ? bcnt_q + 8'h1 : 8'h0;
			since_q <= |rise ? 8'h0 : since_q + {7'h0, since_q != 8'hff};
			wake_q <= !low_power_hold_n ? 16'h0 :
				wake_q + {15'h0, wake_q != 16'hffff};
			conv_q <= (busy_fall ? 3'h0 : conv_q) | rise;
			for (int i = 0; i < 3; i++) begin
				if (busy_fall && conv_q[i] && !pair_sample_trigger[i])
					slp_q[i] <= 1'b1;
				else if (rise[i])
					slp_q[i] <= 1'b0;
				rec_q[i] <= (rise[i] && slp_q[i]) ? 8'h0 :
					rec_q[i] + {7'h0, rec_q[i] != 8'hff};
			end
		end
	end

	sequence s_rise;
		|rise;
	endsequence
	sequence s_conv;
		busy [*8];
	endsequence
	property p_conv_len;
		busy_fall |-> bcnt_q == 8'(appd_pkg::CONV_CYCLES);
	endproperty
	property p_cause;
		$rose(busy) |-> since_q inside {[8'h2:8'h6]};
	endproperty
	property p_conv_hold;
		$rose(busy) |-> s_conv;
	endproperty
	property p_low_power_hold_n_start;
		$rose(busy) |-> wake_q >= WAKEUP_CYCLES;
	endproperty
	property p_low_power_hold_n_hold;
		!low_power_hold_n && !busy |=> !busy;
	endproperty
	property p_low_power_hold_n_idle;
		$fell(low_power_hold_n) |-> !busy;
	endproperty
	property p_wake_wait;
		s_rise |-> low_power_hold_n && wake_q >= WAKEUP_CYCLES;
	endproperty
	property p_ppd_wait(int k);
		rise[k] && !slp_q[k] |-> rec_q[k] >= PPD_CYCLES;
	endproperty

	a_conv_len: assert property (p_conv_len)
		else $error("conversion length wrong");
	a_cause: assert property (p_cause)
		else $error("busy rose without a trigger edge");
	a_conv_hold: assert property (p_conv_hold)
		else $error("busy dropped early");
	a_low_power_hold_n_start: assert property (p_low_power_hold_n_start)
		else $error("conversion inside wake window");
	a_low_power_hold_n_hold: assert property (p_low_power_hold_n_hold)
		else $error("conversion started in standby");
	a_low_power_hold_n_idle: assert property (p_low_power_hold_n_idle)
		else $error("standby entered while busy");
	a_wake_wait: assert property (p_wake_wait)
		else $error("trigger raised before wake-up");
	for (genvar g = 0; g < 3; g++) begin : g_pair
		a_ppd_wait: assert property (p_ppd_wait(g))
			else $error("trigger raised before recovery");
	end
endmodule : appd_properties

// ===== sim/tb_top.sv
// Bench: host and converter ends joined by the link, plus a second
// converter end driven straight from here to break host timing.
// Assumes the package, link and both ends are compiled first.
`timescale 1ns/1ps
module tb_top;
	localparam int unsigned PPD = 6;
	localparam int unsigned WAKE = 10;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] convert_req = 3'h0;
	logic [2:0] sleep_after = 3'h0;
	logic standby_between = 1'b0;
	logic [2:0] sample_in_valid = 3'h7;
	logic req_ready, conv_done, standby_active, reference_on, device_ready;
	logic [2:0] pair_powered_down, result_fresh, slp_exp, pair_ready;
	logic [2:0] e3, rq, rs, rv;
	logic [47:0] result_data;
	logic [9:0] notes [$];
	logic [9:0] nt;
	int err_count = 0;
	int checks = 0;
	appd_link_if link ();
	appd_link_if link_b ();
	appd_host #(.PPD_CYCLES(PPD), .WAKEUP_CYCLES(WAKE)) i_appd_host (
		.clock(clock), .rst_b(rst_b), .link(link),
		.convert_req(convert_req), .sleep_after(sleep_after),
		.standby_between(standby_between), .req_ready(req_ready),
		.conv_done(conv_done));
	appd_device #(.PPD_CYCLES(PPD), .WAKEUP_CYCLES(WAKE)) i_appd_device (
		.clock(clock), .rst_b(rst_b), .link(link),
		.sample_in_valid(sample_in_valid), .pair_ready(pair_ready),
		.pair_powered_down(pair_powered_down), .device_ready(device_ready),
		.standby_active(standby_active), .reference_on(reference_on),
		.result_fresh(result_fresh), .result_data(result_data));
	appd_device #(.PPD_CYCLES(PPD), .WAKEUP_CYCLES(WAKE)) i_appd_device_b (
		.clock(clock), .rst_b(rst_b), .link(link_b),
		.sample_in_valid(sample_in_valid), .pair_ready(),
		.pair_powered_down(), .device_ready(), .standby_active(),
		.reference_on(), .result_fresh(), .result_data());
	appd_properties #(.PPD_CYCLES(PPD), .WAKEUP_CYCLES(WAKE)) u_props (
		.clock(clock), .rst_b(rst_b),
		.pair_sample_trigger(link.pair_sample_trigger),
		.low_power_hold_n(link.low_power_hold_n), .busy(link.busy));

	initial forever #20 clock = ~clock;

	task automatic chk(string name, logic [47:0] exp, logic [47:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	// One request: wait until taken, note the outcome, wait until done.
	task automatic op(logic [2:0] req, logic [2:0] slp, logic stb,
		logic [2:0] vld);
		int n;
		convert_req <= req;
		sleep_after <= slp;
		standby_between <= stb;
		sample_in_valid <= vld;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (req_ready !== 1'b1 && n < 400);
		chk("taken", 48'h1, {47'h0, req_ready});
		convert_req <= 3'h0;
		slp_exp = (slp_exp & ~req) | (req & slp);
		notes.push_back({vld, stb, slp_exp, req});
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (conv_done !== 1'b1 && n < 400);
		chk("done", 48'h1, {47'h0, conv_done});
		repeat (12) @(posedge clock);
	endtask : op

	// Second end: edges that a careful host would never give.
	task automatic pulse(logic [2:0] t, int gap, logic exp, string nm);
		link_b.pair_sample_trigger <= t;
		repeat (gap) @(posedge clock);
		chk(nm, {47'h0, exp}, {47'h0, link_b.busy});
	endtask : pulse

	task automatic fault();
		link_b.low_power_hold_n <= 1'b0;
		repeat (8) @(posedge clock);
		pulse(3'h1, 20, 1'b0, "low_power_hold_n_busy");
		link_b.low_power_hold_n <= 1'b1;
		pulse(3'h0, 2, 1'b0, "idle");
		pulse(3'h2, 6, 1'b0, "wake_busy");
		pulse(3'h0, WAKE + 4, 1'b0, "idle");
		pulse(3'h2, 6, 1'b1, "late_busy");
		pulse(3'h0, 90, 1'b0, "done");
		pulse(3'h2, 2, 1'b0, "wake");
		pulse(3'h0, 3, 1'b0, "wake");
		pulse(3'h2, 6, 1'b0, "ppd_busy");
		pulse(3'h0, PPD + 4, 1'b0, "rec_idle");
		pulse(3'h2, 6, 1'b1, "rec_busy");
	endtask : fault

	// The settled state after each conversion is matched to its note.
	initial forever begin
		@(posedge clock);
		if (conv_done === 1'b1) begin
			nt = notes.pop_front();
			repeat (8) @(posedge clock);
			e3 = nt[2:0] & nt[9:7];
			chk("fresh", {45'h0, e3}, {45'h0, result_fresh});
			chk("ppd", {45'h0, nt[5:3]}, {45'h0, pair_powered_down});
			chk("low_power_hold_n", {47'h0, nt[6]}, {47'h0, standby_active});
			chk("ref", {47'h0, !nt[6]}, {47'h0, reference_on});
			chk("dev_rdy", {47'h0, !nt[6]}, {47'h0, device_ready});
			e3 = ~nt[5:3] & {3{!nt[6]}};
			chk("pair_rdy", {45'h0, e3}, {45'h0, pair_ready});
			for (int p = 0; p < 3; p++)
				if (!nt[p])
					chk("data", 48'h0, result_data & (48'hffff << 16 * p));
		end
	end

	initial begin
		repeat (30000) @(posedge clock);
		err_count++;
		summarize();
	end

	initial begin
		link_b.pair_sample_trigger = 3'h0;
		link_b.low_power_hold_n = 1'b1;
		slp_exp = 3'h0;
		void'($urandom(32'hf4ed));
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		repeat (4) @(posedge clock);
		op(3'h7, 3'h5, 1'b0, 3'h7);
		op(3'h2, 3'h0, 1'b0, 3'h7);
		op(3'h5, 3'h0, 1'b1, 3'h6);
		op(3'h1, 3'h1, 1'b0, 3'h7);
		for (int i = 0; i < 10; i++) begin
			rq = 3'($urandom_range(7, 1));
			rs = 3'($urandom);
			rv = 3'($urandom);
			op(rq, rs, 1'($urandom), rv);
		end
		fault();
		summarize();
	end
endmodule : tb_top
